// [logic/status_power_control_reg.sv]
// status and power-control register with low-power entry and exit sequencing
`timescale 1ns/10ps
`default_nettype none

module status_power_control_reg #(
    parameter logic [3:0] product_revision = 4'h1, // arbitrary value
    parameter int unsigned nv_words = status_power_pkg::nv_page_words,
    parameter int unsigned nv_addr_width = status_power_pkg::nv_addr_width
) (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    // register port of the serial host front end
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [15:0] reg_wdata_i,
    output logic [15:0] reg_rdata_o,
    output logic reg_ack_o,
    // fuse-backed defaults of the idle-select and both exit-disable fields
    input wire logic fuse_idle_behaviour_select_i,
    input wire logic fuse_exit_pin_sampling_disable_i,
    input wire logic fuse_exit_nv_reload_disable_i,
    // clock status and outputs
    input wire logic clock_ready_i,
    input wire logic out0_enable_i,
    input wire logic out1_enable_i,
    output logic outputs_mute_o,
    output logic low_power_o,
    // reference-control pin, two-way
    input wire logic refctl_is_ready_output_i,
    input wire logic refctl_pin_i,
    output logic refctl_pin_o,
    output logic refctl_pin_oe_o,
    // configuration pins
    input wire logic format_address_pin_i,
    input wire logic clock_select0_pin_i,
    input wire logic data_select1_pin_i,
    output logic nv_preset_mode_o,
    output logic [2:0] sampled_pins_o,
    // nonvolatile page 0 and configuration register write port
    output logic [nv_addr_width-1:0] nv_addr_o,
    output logic nv_rd_o,
    input wire logic [15:0] nv_data_i,
    output logic [nv_addr_width-1:0] cfg_addr_o,
    output logic [15:0] cfg_wdata_o,
    output logic cfg_wr_o,
    output logic exit_busy_o
);

    logic reserved_top_reg;
    logic reserved_top_next;
    logic reserved_low_reg;
    logic reserved_low_next;
    logic idle_sel_reg;
    logic idle_sel_next;
    logic pin_samp_dis_reg;
    logic pin_samp_dis_next;
    logic nv_reload_dis_reg;
    logic nv_reload_dis_next;
    logic power_down_reg;
    logic power_down_next;
    logic [15:0] rdata_reg;
    logic [15:0] rdata_next;
    logic ack_reg;
    logic ack_next;
    status_power_pkg::pwr_state_e state_reg;
    status_power_pkg::pwr_state_e state_next;
    logic mute_reg;
    logic mute_next;
    logic sample_req_reg;
    logic sample_req_next;
    logic load_req_reg;
    logic load_req_next;
    logic hit;
    logic both_disabled;
    logic want_low_power;
    logic [15:0] status_word;
    logic sampled;
    logic loader_busy;

    assign hit = (reg_addr_i == status_power_pkg::status_power_control_offset);
    assign both_disabled = !out0_enable_i && !out1_enable_i;

    // idle select 0 turns a full output disable into a low-power entry
    assign want_low_power = power_down_reg
        || (both_disabled && !idle_sel_reg);

    // read view of the register; bit 9 always reads zero
    always_comb begin
        status_word = 16'h0000;
        status_word[status_power_pkg::reserved_top_bit] = reserved_top_reg;
        status_word[status_power_pkg::product_revision_lsb +:
            status_power_pkg::product_revision_width] = product_revision;
        status_word[status_power_pkg::clock_ready_bit] = clock_ready_i;
        status_word[status_power_pkg::reserved_ro_bit] = 1'b0;
        status_word[status_power_pkg::refctl_pin_readback_bit] = refctl_pin_i;
        status_word[status_power_pkg::data_select1_pin_readback_bit] = data_select1_pin_i;
        status_word[status_power_pkg::clock_select0_pin_readback_bit] = clock_select0_pin_i;
        status_word[status_power_pkg::format_address_pin_readback_bit] = format_address_pin_i;
        status_word[status_power_pkg::idle_behaviour_select_bit] = idle_sel_reg;
        status_word[status_power_pkg::exit_pin_sampling_disable_bit] = pin_samp_dis_reg;
        status_word[status_power_pkg::exit_nv_reload_disable_bit] = nv_reload_dis_reg;
        status_word[status_power_pkg::power_down_bit_pos] = power_down_reg;
        status_word[status_power_pkg::reserved_low_bit] = reserved_low_reg;
    end

    // register access: writes land in one cycle, reads answer with a registered word
    always_comb begin
        reserved_top_next = reserved_top_reg;
        reserved_low_next = reserved_low_reg;
        idle_sel_next = idle_sel_reg;
        pin_samp_dis_next = pin_samp_dis_reg;
        nv_reload_dis_next = nv_reload_dis_reg;
        power_down_next = power_down_reg;
        rdata_next = rdata_reg;
        ack_next = reg_wr_i || reg_rd_i;
        if (reg_wr_i && hit) begin
            // reserved bits keep what the host wrote; only zero is expected there
            reserved_top_next = reg_wdata_i[status_power_pkg::reserved_top_bit];
            reserved_low_next = reg_wdata_i[status_power_pkg::reserved_low_bit];
            idle_sel_next = reg_wdata_i[status_power_pkg::idle_behaviour_select_bit];
            // accepted at any time; outside low power they only take effect at next exit
            pin_samp_dis_next = reg_wdata_i[status_power_pkg::exit_pin_sampling_disable_bit];
            nv_reload_dis_next = reg_wdata_i[status_power_pkg::exit_nv_reload_disable_bit];
            power_down_next = reg_wdata_i[status_power_pkg::power_down_bit_pos];
        end
        if (reg_rd_i) begin
            // unmapped offsets read as zero
            rdata_next = hit ? status_word : 16'h0000;
        end
    end

    // synchronous reset, so the fuse defaults may be loaded directly
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            reserved_top_reg <= status_power_pkg::reserved_bit_reset;
            reserved_low_reg <= status_power_pkg::reserved_bit_reset;
            idle_sel_reg <= fuse_idle_behaviour_select_i;
            pin_samp_dis_reg <= fuse_exit_pin_sampling_disable_i;
            nv_reload_dis_reg <= fuse_exit_nv_reload_disable_i;
            power_down_reg <= status_power_pkg::power_down_reset;
            rdata_reg <= 16'h0000;
            ack_reg <= 1'b0;
        end else begin
            reserved_top_reg <= reserved_top_next;
            reserved_low_reg <= reserved_low_next;
            idle_sel_reg <= idle_sel_next;
            pin_samp_dis_reg <= pin_samp_dis_next;
            nv_reload_dis_reg <= nv_reload_dis_next;
            power_down_reg <= power_down_next;
            rdata_reg <= rdata_next;
            ack_reg <= ack_next;
        end
    end

    // power sequencer: exit steps run in order, resample first then reload
    always_comb begin
        state_next = state_reg;
        sample_req_next = 1'b0;
        load_req_next = 1'b0;
        mute_next = both_disabled;
        case (state_reg)
            status_power_pkg::pwr_active: begin
                if (want_low_power) begin
                    state_next = status_power_pkg::pwr_low;
                end
            end
            status_power_pkg::pwr_low: begin
                mute_next = 1'b1;
                if (!want_low_power) begin
                    if (!pin_samp_dis_reg) begin
                        state_next = status_power_pkg::pwr_exit_sample;
                        sample_req_next = 1'b1;
                    end else if (!nv_reload_dis_reg) begin
                        state_next = status_power_pkg::pwr_exit_load;
                        load_req_next = 1'b1;
                    end else begin
                        state_next = status_power_pkg::pwr_active;
                    end
                end
            end
            status_power_pkg::pwr_exit_sample: begin
                mute_next = 1'b1;
                if (sampled) begin
                    if (!nv_reload_dis_reg) begin
                        state_next = status_power_pkg::pwr_exit_load;
                        load_req_next = 1'b1;
                    end else begin
                        state_next = status_power_pkg::pwr_active;
                    end
                end
            end
            status_power_pkg::pwr_exit_load: begin
                mute_next = 1'b1;
                state_next = status_power_pkg::pwr_exit_wait;
            end
            status_power_pkg::pwr_exit_wait: begin
                mute_next = 1'b1;
                if (!loader_busy) begin
                    state_next = status_power_pkg::pwr_active;
                end
            end
            default: begin
                state_next = status_power_pkg::pwr_active;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            state_reg <= status_power_pkg::pwr_active;
            sample_req_reg <= 1'b0;
            load_req_reg <= 1'b0;
            mute_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            sample_req_reg <= sample_req_next;
            load_req_reg <= load_req_next;
            mute_reg <= mute_next;
        end
    end

    config_pin_sampler u_pins (
        .sys_clk_i(sys_clk_i),
        .resetn_i(resetn_i),
        .sample_i(sample_req_reg),
        .format_address_pin_i(format_address_pin_i),
        .clock_select0_pin_i(clock_select0_pin_i),
        .data_select1_pin_i(data_select1_pin_i),
        .sampled_pins_o(sampled_pins_o),
        .nv_preset_mode_o(nv_preset_mode_o),
        .sampled_o(sampled)
    );

    nv_page_loader #(
        .words(nv_words),
        .addr_width(nv_addr_width),
        .data_width(status_power_pkg::nv_word_width)
    ) u_loader (
        .sys_clk_i(sys_clk_i),
        .resetn_i(resetn_i),
        .start_i(load_req_reg),
        .nv_addr_o(nv_addr_o),
        .nv_rd_o(nv_rd_o),
        .nv_data_i(nv_data_i),
        .cfg_addr_o(cfg_addr_o),
        .cfg_wdata_o(cfg_wdata_o),
        .cfg_wr_o(cfg_wr_o),
        .busy_o(loader_busy)
    );

    assign reg_rdata_o = rdata_reg;
    assign reg_ack_o = ack_reg;
    assign outputs_mute_o = mute_reg;
    assign low_power_o = (state_reg == status_power_pkg::pwr_low);
    // pin mirrors the live status only when configured as a ready output
    assign refctl_pin_o = clock_ready_i;
    assign refctl_pin_oe_o = refctl_is_ready_output_i;
    assign exit_busy_o = (state_reg != status_power_pkg::pwr_active)
        && (state_reg != status_power_pkg::pwr_low);

endmodule // status_power_control_reg

`default_nettype wire

// [logic/status_power_pkg.sv]
// constants for the status and power-control register block
package status_power_pkg;

    localparam logic [7:0] status_power_control_offset = 8'h0a;
    localparam int unsigned reg_width = 16;
    localparam logic [15:0] status_power_control_reset = 16'h0010;

    // field positions
    localparam int unsigned reserved_top_bit = 15;
    localparam int unsigned product_revision_lsb = 11;
    localparam int unsigned product_revision_width = 4;
    localparam int unsigned clock_ready_bit = 10;
    localparam int unsigned reserved_ro_bit = 9;
    localparam int unsigned refctl_pin_readback_bit = 8;
    localparam int unsigned data_select1_pin_readback_bit = 7;
    localparam int unsigned clock_select0_pin_readback_bit = 6;
    localparam int unsigned format_address_pin_readback_bit = 5;
    localparam int unsigned idle_behaviour_select_bit = 4;
    localparam int unsigned exit_pin_sampling_disable_bit = 3;
    localparam int unsigned exit_nv_reload_disable_bit = 2;
    localparam int unsigned power_down_bit_pos = 1;
    localparam int unsigned reserved_low_bit = 0;

    // reset values of the writable fields without a fuse default
    localparam logic power_down_reset = 1'b0;
    localparam logic reserved_bit_reset = 1'b0;

    // nonvolatile page 0 reload
    localparam int unsigned nv_page_words = 16;
    localparam int unsigned nv_addr_width = 4;
    localparam int unsigned nv_word_width = 16;

    // power sequencer states
    typedef enum logic [2:0] {
        pwr_active = 3'b000,
        pwr_low = 3'b001,
        pwr_exit_sample = 3'b010,
        pwr_exit_load = 3'b011,
        pwr_exit_wait = 3'b100
    } pwr_state_e;

endpackage : status_power_pkg

// [logic/config_pin_sampler.sv]
// captures the three configuration pins and derives the configuration mode
`timescale 1ns/10ps
`default_nettype none

module config_pin_sampler (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic sample_i,
    input wire logic format_address_pin_i,
    input wire logic clock_select0_pin_i,
    input wire logic data_select1_pin_i,
    output logic [2:0] sampled_pins_o,
    output logic nv_preset_mode_o,
    output logic sampled_o
);

    logic first_reg;
    logic first_next;
    logic [2:0] pins_reg;
    logic [2:0] pins_next;
    logic mode_reg;
    logic mode_next;
    logic done_reg;
    logic done_next;

    // pins are caught once after reset release and again on each request
    always_comb begin
        first_next = 1'b0;
        pins_next = pins_reg;
        mode_next = mode_reg;
        done_next = 1'b0;
        if (first_reg || sample_i) begin
            pins_next = {data_select1_pin_i, clock_select0_pin_i, format_address_pin_i};
            mode_next = format_address_pin_i;
            done_next = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            first_reg <= 1'b1;
            pins_reg <= 3'h0;
            mode_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            first_reg <= first_next;
            pins_reg <= pins_next;
            mode_reg <= mode_next;
            done_reg <= done_next;
        end
    end

    assign sampled_pins_o = pins_reg;
    assign nv_preset_mode_o = mode_reg;
    assign sampled_o = done_reg;

endmodule // config_pin_sampler

`default_nettype wire

// [logic/nv_page_loader.sv]
// walks nonvolatile page 0 and writes each word into the configuration registers
`timescale 1ns/10ps
`default_nettype none

module nv_page_loader #(
    parameter int unsigned words = status_power_pkg::nv_page_words,
    parameter int unsigned addr_width = status_power_pkg::nv_addr_width,
    parameter int unsigned data_width = status_power_pkg::nv_word_width
) (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic start_i,
    output logic [addr_width-1:0] nv_addr_o,
    output logic nv_rd_o,
    input wire logic [data_width-1:0] nv_data_i,
    output logic [addr_width-1:0] cfg_addr_o,
    output logic [data_width-1:0] cfg_wdata_o,
    output logic cfg_wr_o,
    output logic busy_o
);

    localparam logic [addr_width-1:0] last_addr = addr_width'(words - 1);

    logic busy_reg;
    logic busy_next;
    logic [addr_width-1:0] addr_reg;
    logic [addr_width-1:0] addr_next;
    logic rd_d_reg;
    logic rd_d_next;
    logic [addr_width-1:0] raddr_d_reg;
    logic [addr_width-1:0] raddr_d_next;
    logic wr_reg;
    logic wr_next;
    logic [addr_width-1:0] waddr_reg;
    logic [addr_width-1:0] waddr_next;
    logic [data_width-1:0] wdata_reg;
    logic [data_width-1:0] wdata_next;

    // nonvolatile read data is one cycle behind its address
    always_comb begin
        busy_next = busy_reg;
        addr_next = addr_reg;
        // address and strobe are held back one stage so they meet their data
        rd_d_next = busy_reg;
        raddr_d_next = addr_reg;
        wr_next = rd_d_reg;
        waddr_next = raddr_d_reg;
        wdata_next = rd_d_reg ? nv_data_i : wdata_reg;
        if (start_i && !busy_reg) begin
            busy_next = 1'b1;
            addr_next = '0;
        end else if (busy_reg) begin
            if (addr_reg == last_addr) begin
                busy_next = 1'b0;
            end else begin
                addr_next = addr_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            busy_reg <= 1'b0;
            addr_reg <= '0;
            rd_d_reg <= 1'b0;
            raddr_d_reg <= '0;
            wr_reg <= 1'b0;
            waddr_reg <= '0;
            wdata_reg <= '0;
        end else begin
            busy_reg <= busy_next;
            addr_reg <= addr_next;
            rd_d_reg <= rd_d_next;
            raddr_d_reg <= raddr_d_next;
            wr_reg <= wr_next;
            waddr_reg <= waddr_next;
            wdata_reg <= wdata_next;
        end
    end

    assign nv_addr_o = addr_reg;
    assign nv_rd_o = busy_reg;
    assign cfg_addr_o = waddr_reg;
    assign cfg_wdata_o = wdata_reg;
    assign cfg_wr_o = wr_reg;
    assign busy_o = busy_reg | rd_d_reg | wr_reg;

endmodule // nv_page_loader

`default_nettype wire

// [tb/nv_page_model.sv]
// nonvolatile page 0 store that answers the reload walk one cycle after each address
`timescale 1ns/10ps
`default_nettype none

module nv_page_model (
    input wire logic sys_clk_i,
    input wire logic nv_rd_i,
    input wire logic [3:0] nv_addr_i,
    output logic [15:0] nv_data_o
);
    initial nv_data_o = 16'h0000;
    always @(posedge sys_clk_i) begin
        // outside a read the bus flips each cycle so stale data never matches
        nv_data_o <= nv_rd_i ? {4'ha, nv_addr_i, ~nv_addr_i, 4'h5 ^ nv_addr_i} : ~nv_data_o;
    end
endmodule // nv_page_model
`default_nettype wire

// [tb/status_power_control_reg_props.sv]
// port assertions of the status and power-control register
`timescale 1ns/10ps
`default_nettype none

module status_power_control_reg_props #(
    parameter int unsigned nv_addr_width = 4
) (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic [15:0] reg_rdata_o,
    input wire logic reg_ack_o,
    input wire logic clock_ready_i,
    input wire logic out0_enable_i,
    input wire logic out1_enable_i,
    input wire logic outputs_mute_o,
    input wire logic low_power_o,
    input wire logic refctl_is_ready_output_i,
    input wire logic refctl_pin_o,
    input wire logic refctl_pin_oe_o,
    input wire logic [nv_addr_width-1:0] nv_addr_o,
    input wire logic nv_rd_o,
    input wire logic [nv_addr_width-1:0] cfg_addr_o,
    input wire logic cfg_wr_o,
    input wire logic exit_busy_o
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!resetn_i);

    sequence mapped_read_s;
        reg_rd_i && reg_addr_i == 8'h0a;
    endsequence
    sequence pdn_write_s;
        reg_wr_i && reg_addr_i == 8'h0a && reg_wdata_i[1];
    endsequence
    sequence exit_start_s;
        $fell(low_power_o);
    endsequence

    ack_after_strobe_a: assert property ((reg_wr_i || reg_rd_i) |=> reg_ack_o)
        else $error("ack missing after strobe");
    ack_needs_strobe_a: assert property (!(reg_wr_i || reg_rd_i) |=> !reg_ack_o)
        else $error("ack without strobe");
    ready_bit_read_a: assert property (mapped_read_s |=> reg_rdata_o[10:9] == {$past(clock_ready_i), 1'b0})
        else $error("ready or reserved bit wrong");
    unmapped_read_zero_a: assert property (reg_rd_i && reg_addr_i != 8'h0a |=> reg_rdata_o == 16'h0000)
        else $error("unmapped read not zero");
    refctl_mirror_a: assert property (refctl_pin_oe_o == refctl_is_ready_output_i && (!refctl_pin_oe_o || refctl_pin_o == clock_ready_i))
        else $error("reference pin does not mirror ready");
    pdn_entry_a: assert property (pdn_write_s |-> ##2 low_power_o)
        else $error("power-down write did not enter low power");
    idle_mute_a: assert property ($past(resetn_i) && !$past(out0_enable_i) && !$past(out1_enable_i) |-> outputs_mute_o)
        else $error("outputs not muted while disabled");
    low_power_mute_a: assert property (low_power_o && $past(low_power_o) |-> outputs_mute_o)
        else $error("outputs not muted in low power");
    exit_bound_a: assert property (exit_start_s |-> ##[0:24] !exit_busy_o)
        else $error("exit sequence too long");
    load_pairing_a: assert property (cfg_wr_o |-> cfg_addr_o == $past(nv_addr_o, 2) && exit_busy_o)
        else $error("reload write out of place");
    load_addr_step_a: assert property (nv_rd_o && $past(nv_rd_o) |-> nv_addr_o - $past(nv_addr_o) == nv_addr_width'(1))
        else $error("reload address skipped");
    exit_load_c: cover property (exit_start_s ##[1:8] nv_rd_o);
endmodule // status_power_control_reg_props

bind status_power_control_reg status_power_control_reg_props #(.nv_addr_width(nv_addr_width)) u_props (
    .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .reg_ack_o(reg_ack_o), .clock_ready_i(clock_ready_i), .out0_enable_i(out0_enable_i),
    .out1_enable_i(out1_enable_i), .outputs_mute_o(outputs_mute_o), .low_power_o(low_power_o),
    .refctl_is_ready_output_i(refctl_is_ready_output_i), .refctl_pin_o(refctl_pin_o),
    .refctl_pin_oe_o(refctl_pin_oe_o), .nv_addr_o(nv_addr_o), .nv_rd_o(nv_rd_o),
    .cfg_addr_o(cfg_addr_o), .cfg_wr_o(cfg_wr_o), .exit_busy_o(exit_busy_o)
);
`default_nettype wire

// [tb/status_power_control_reg_test.sv]
// self-checking bench of the status and power-control register
`timescale 1ns/10ps
`default_nettype none

module status_power_control_reg_test;
    localparam logic [3:0] rev = 4'h6; // arbitrary value
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] addr = 8'h00;
    logic wr = 1'b0, rd = 1'b0;
    logic [15:0] wdata = 16'h0000, sh, rdata, nv_data, cfg_wdata;
    logic [2:0] fuse = 3'b100, exp_pins, sampled;
    logic clock_ready = 1'b1, out0_en = 1'b1, out1_en = 1'b1, ref_sel = 1'b0, ext_ref = 1'b0;
    logic fmt = 1'b1, cs0 = 1'b0, ds1 = 1'b1, ref_wire, ref_o, ref_oe;
    logic ack, mute, low_power, preset, nv_rd, cfg_wr, busy;
    logic [3:0] nv_addr, cfg_addr;
    logic [31:0] r = 32'h70d41095;
    int err_total = 0, num_checks = 0, cfg_count = 0, k, n;

    always #20 sys_clk = ~sys_clk;
    assign ref_wire = ref_oe ? ref_o : ext_ref;

    status_power_control_reg #(.product_revision(rev)) u_dut (
        .sys_clk_i(sys_clk), .resetn_i(resetn), .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_ack_o(ack),
        .fuse_idle_behaviour_select_i(fuse[2]), .fuse_exit_pin_sampling_disable_i(fuse[1]),
        .fuse_exit_nv_reload_disable_i(fuse[0]), .clock_ready_i(clock_ready),
        .out0_enable_i(out0_en), .out1_enable_i(out1_en), .outputs_mute_o(mute),
        .low_power_o(low_power), .refctl_is_ready_output_i(ref_sel), .refctl_pin_i(ref_wire),
        .refctl_pin_o(ref_o), .refctl_pin_oe_o(ref_oe), .format_address_pin_i(fmt),
        .clock_select0_pin_i(cs0), .data_select1_pin_i(ds1), .nv_preset_mode_o(preset),
        .sampled_pins_o(sampled), .nv_addr_o(nv_addr), .nv_rd_o(nv_rd), .nv_data_i(nv_data),
        .cfg_addr_o(cfg_addr), .cfg_wdata_o(cfg_wdata), .cfg_wr_o(cfg_wr), .exit_busy_o(busy)
    );
    nv_page_model u_nv (.sys_clk_i(sys_clk), .nv_rd_i(nv_rd), .nv_addr_i(nv_addr), .nv_data_o(nv_data));

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic logic [15:0] nv_word(input logic [3:0] a);
        nv_word = {4'ha, a, ~a, 4'h5 ^ a};
    endfunction
    function automatic logic [15:0] exp_word(input logic [15:0] s);
        exp_word = s & 16'h801f;
        exp_word[14:11] = rev;
        exp_word[10] = clock_ready;
        exp_word[8:5] = {ref_sel ? clock_ready : ext_ref, ds1, cs0, fmt};
    endfunction

    task automatic end_sim;
        if (err_total == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t word %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t flag %b expected %b", $time, got, exp);
        end
    endtask
    task automatic access(input logic w, input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        wr <= w;
        rd <= !w;
        addr <= a;
        wdata <= d;
        @(posedge sys_clk);
        wr <= 1'b0;
        rd <= 1'b0;
        #1;
        chk_bit(ack, 1'b1);
        if (!w) begin
            chk_word(rdata, a == 8'h0a ? exp_word(sh) : 16'h0000);
        end
    endtask
    task automatic do_reset(input logic [2:0] f);
        @(posedge sys_clk);
        resetn <= 1'b0;
        fuse <= f;
        repeat (5) @(posedge sys_clk);
        resetn <= 1'b1;
        exp_pins = {ds1, cs0, fmt};
        sh = {11'h000, f, 2'b00};
        access(1'b0, 8'h0a, 16'h0000);
        chk_word({13'h0000, sampled}, {13'h0000, exp_pins});
    endtask

    always @(posedge sys_clk) begin
        if (cfg_wr === 1'b1) begin
            chk_word({12'h000, cfg_addr}, 16'(cfg_count));
            chk_word(cfg_wdata, nv_word(cfg_addr));
            cfg_count++;
        end
    end

    initial begin
        #(40 * 20000);
        err_total++;
        end_sim;
    end

    initial begin
        do_reset(3'b100);
        chk_word(rdata & 16'h801f, 16'h0010);
        for (k = 0; k < 40; k++) begin
            r = lfsr(r);
            @(posedge sys_clk);
            {clock_ready, fmt, cs0, ds1, ref_sel, ext_ref} <= r[5:0];
            if (r[7]) begin
                access(r[6], r[15:8] == 8'h0a ? 8'h0b : r[15:8], r[31:16]);
            end else if (r[6]) begin
                sh[4] = r[9];
                // bits 15 and 0 stay zero, bits 3 and 2 are left alone outside low power
                access(1'b1, 8'h0a, sh);
            end else begin
                access(1'b0, 8'h0a, 16'h0000);
            end
        end
        for (k = 0; k < 4; k++) begin
            cfg_count = 0;
            sh[1] = 1'b1;
            access(1'b1, 8'h0a, sh);
            repeat (2) @(posedge sys_clk);
            #1;
            chk_bit(low_power, 1'b1);
            sh[3:2] = 2'(k);
            access(1'b1, 8'h0a, sh);
            r = lfsr(r);
            @(posedge sys_clk);
            {ds1, cs0, fmt} <= {r[1:0], ~fmt};
            #1;
            if (!sh[3]) begin
                exp_pins = {ds1, cs0, fmt};
            end
            sh[1] = 1'b0;
            access(1'b1, 8'h0a, sh);
            repeat (2) @(posedge sys_clk);
            #1;
            for (n = 0; n < 40 && busy !== 1'b0; n++) begin
                @(posedge sys_clk);
                #1;
            end
            chk_bit(low_power, 1'b0);
            chk_word({13'h0000, sampled}, {13'h0000, exp_pins});
            chk_bit(preset, exp_pins[0]);
            chk_word(16'(cfg_count), sh[2] ? 16'h0000 : 16'h0010);
            access(1'b0, 8'h0a, 16'h0000);
        end
        for (k = 0; k < 2; k++) begin
            sh[4] = k[0];
            access(1'b1, 8'h0a, sh);
            @(posedge sys_clk);
            {out0_en, out1_en} <= 2'b00;
            repeat (3) @(posedge sys_clk);
            #1;
            chk_bit(mute, 1'b1);
            chk_bit(low_power, !k[0]);
            @(posedge sys_clk);
            {out0_en, out1_en} <= 2'b11;
            repeat (4) @(posedge sys_clk);
            #1;
            chk_bit(low_power, 1'b0);
        end
        sh[4] = 1'b1;
        // keep low power off on output disable, restart stays fast
        access(1'b1, 8'h0a, sh);
        do_reset(3'b011);
        end_sim;
    end
endmodule // status_power_control_reg_test
`default_nettype wire
